// ==== psco_core.v ====
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "psco_defs.vh"
module psco_core (
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [3:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_frame_valid,
  input  wire [15:0] i_frame_data,
  output reg         o_frame_req,
  output reg  [31:0] o_frame_addr,
  output reg         o_fp_abort,
  output reg         o_fp_reset,
  output reg         o_fp_resume,
  output reg         o_fp_idle,
  output reg         o_fp_e1_only,
  output reg         o_int_hold,
  output reg         o_cache_req,
  output reg  [1:0]  o_cache_sel,
  output reg         o_cache_push,
  output reg  [1:0]  o_cache_scope,
  output reg  [31:0] o_cache_addr,
  output reg  [31:0] o_cache_mask,
  input  wire        i_cache_done,
  output reg         o_cp_save_req,
  output reg  [2:0]  o_cp_id,
  input  wire        i_cp_done
);
  // states
  localparam ST_IDLE  = 3'd0;
  localparam ST_FMT   = 3'd1;
  localparam ST_BODY  = 3'd2;
  localparam ST_CACHE = 3'd3;
  localparam ST_CP    = 3'd4;

  reg [2:0]  state_r;       // sequencer state
  reg [15:0] opcode_r;      // command word
  reg [15:0] operand_r;     // immediate word
  reg [31:0] areg_r;        // named address register value
  reg [15:0] sr_r;          // status word
  reg [31:0] fpsr_r;        // fp status register
  reg        page8k_r;      // page size select
  reg [2:0]  result_r;      // last completion code
  reg        busy_r;        // operation in flight
  reg [7:0]  frame_size_r;  // size from format word
  reg [7:0]  frame_left_r;  // bytes still to read
  reg        frame_sync_r;  // sync stage one (read only by stage two)
  reg        frame_sync2_r; // synced frame valid
  reg        frame_seen_r;  // edge helper
  reg        cdone_s1_r;    // cache done sync
  reg        cdone_s2_r;
  reg        cpdone_s1_r;   // coprocessor done sync
  reg        cpdone_s2_r;
  reg [15:0] fdata_r;       // frame word, sampled late enough
  reg [15:0] fdata_s1_r;    // frame word, first stage

  // decoded opcode fields
  wire [2:0] ea_mode = opcode_r[5:3];
  wire [2:0] ea_reg  = opcode_r[2:0];
  wire [2:0] cp_id   = opcode_r[11:9];
  wire [1:0] cfield  = opcode_r[7:6];
  wire [1:0] sfield  = opcode_r[4:3];
  wire       supv    = sr_r[`PSCO_SR_SUPV];
  wire       is_xor  = (opcode_r == `PSCO_OP_XORSR);
  wire       is_push = (opcode_r[15:8] == `PSCO_OP_PUSH_HI) && opcode_r[5];
  wire       is_save = (opcode_r[15:12] == `PSCO_FLINE) && opcode_r[8:6] == `PSCO_SUB_SAVE;
  wire       is_rest = (opcode_r[15:12] == `PSCO_FLINE) && opcode_r[8:6] == `PSCO_SUB_REST;
  wire       frame_rise = frame_sync2_r & ~frame_seen_r;

  // save ea legality: predecrement or control alterable
  wire save_ea_ok = (ea_mode == `PSCO_EA_IND) || (ea_mode == `PSCO_EA_PREDEC) ||
                    (ea_mode == `PSCO_EA_DISP) || (ea_mode == `PSCO_EA_INDEX) ||
                    (ea_mode == `PSCO_EA_EXT && (ea_reg == `PSCO_EAR_ABSW ||
                     ea_reg == `PSCO_EAR_ABSL));
  // restore ea legality: postincrement or control, pc-relative allowed
  wire rest_ea_ok = (ea_mode == `PSCO_EA_IND) || (ea_mode == `PSCO_EA_POSTINC) ||
                    (ea_mode == `PSCO_EA_DISP) || (ea_mode == `PSCO_EA_INDEX) ||
                    (ea_mode == `PSCO_EA_EXT && (ea_reg == `PSCO_EAR_ABSW ||
                     ea_reg == `PSCO_EAR_ABSL || ea_reg == `PSCO_EAR_PCD ||
                     ea_reg == `PSCO_EAR_PCX));

  // format word: size recognised and revision matches
  wire [7:0] fw_size = fdata_r[7:0];
  wire [7:0] fw_rev  = fdata_r[15:8];
  wire size_known = (fw_size == `PSCO_FR_IDLE4)  || (fw_size == `PSCO_FR_IDLE28) ||
                    (fw_size == `PSCO_FR_IDLE60) || (fw_size == `PSCO_FR_UNIMPLEMENTED_FRAME)  ||
                    (fw_size == `PSCO_FR_BUSY96) || (fw_size == `PSCO_FR_BUSY184) ||
                    (fw_size == `PSCO_FR_BUSY216);

  // wishbone write strobe, one per accepted cycle
  wire wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr  = wb_hit & i_wb_we;
  wire go     = wb_wr && i_wb_adr == `PSCO_ADR_CTRL && i_wb_dat[0] && i_wb_sel[0] && !busy_r;

  // synchronisers for far-side handshakes (they are outside our timing)
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      frame_sync_r  <= 1'b0;
      frame_sync2_r <= 1'b0;
      frame_seen_r  <= 1'b0;
      cdone_s1_r    <= 1'b0;
      cdone_s2_r    <= 1'b0;
      cpdone_s1_r   <= 1'b0;
      cpdone_s2_r   <= 1'b0;
      fdata_s1_r    <= 16'h0000;
      fdata_r       <= 16'h0000;
    end else begin
      frame_sync_r  <= i_frame_valid;
      frame_sync2_r <= frame_sync_r;
      frame_seen_r  <= frame_sync2_r;
      cdone_s1_r    <= i_cache_done;
      cdone_s2_r    <= cdone_s1_r;
      cpdone_s1_r   <= i_cp_done;
      cpdone_s2_r   <= cpdone_s1_r;
      // data is held stable by the far side while valid stands
      fdata_s1_r    <= i_frame_data;
      fdata_r       <= fdata_s1_r;
    end
  end

  // wishbone slave: single-cycle ack, unmapped reads return zero
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_hit;
      // read mux, valid with ack
      case (i_wb_adr)
        `PSCO_ADR_CMD:     o_wb_dat <= {16'h0000, opcode_r};
        `PSCO_ADR_OPERAND: o_wb_dat <= {16'h0000, operand_r};
        `PSCO_ADR_AREG:    o_wb_dat <= areg_r;
        `PSCO_ADR_STATUS:  o_wb_dat <= {16'h0000, sr_r};
        `PSCO_ADR_RESULT:  o_wb_dat <= {24'h000000, frame_size_r[4:0], result_r} & 32'h000000ff
                                       | {15'h0000, busy_r, 16'h0000};
        `PSCO_ADR_CTRL:    o_wb_dat <= {30'h00000000, page8k_r, busy_r};
        `PSCO_ADR_FPSR:    o_wb_dat <= fpsr_r;
        `PSCO_ADR_FRAME:   o_wb_dat <= {24'h000000, frame_size_r};
        default:           o_wb_dat <= 32'h00000000;
      endcase
    end
  end

  // main sequencer and register writes
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r      <= ST_IDLE;
      opcode_r     <= 16'h0000;
      operand_r    <= 16'h0000;
      areg_r       <= 32'h00000000;
      sr_r         <= `PSCO_SR_RESET;
      fpsr_r       <= 32'h00000000;
      page8k_r     <= 1'b0;
      result_r     <= `PSCO_RES_OK;
      busy_r       <= 1'b0;
      frame_size_r <= 8'h00;
      frame_left_r <= 8'h00;

      o_frame_req  <= 1'b0;
      o_frame_addr <= 32'h00000000;
      o_fp_abort   <= 1'b0;
      o_fp_reset   <= 1'b0;
      o_fp_resume  <= 1'b0;
      o_fp_idle    <= 1'b0;
      o_fp_e1_only <= 1'b0;
      o_int_hold   <= 1'b0;
      o_cache_req  <= 1'b0;
      o_cache_sel  <= 2'h0;
      o_cache_push <= 1'b0;
      o_cache_scope<= 2'h0;
      o_cache_addr <= 32'h00000000;
      o_cache_mask <= 32'h00000000;

      o_cp_save_req<= 1'b0;
      o_cp_id      <= 3'h0;
    end else begin
      // one-cycle pulses default low
      o_fp_abort   <= 1'b0;
      o_fp_reset   <= 1'b0;
      o_fp_resume  <= 1'b0;
      o_fp_idle    <= 1'b0;
      o_fp_e1_only <= 1'b0;

      // software register writes while idle
      if (wb_wr && !busy_r) begin
        case (i_wb_adr)
          `PSCO_ADR_CMD:     opcode_r  <= i_wb_dat[15:0];
          `PSCO_ADR_OPERAND: operand_r <= i_wb_dat[15:0];
          `PSCO_ADR_AREG:    areg_r    <= i_wb_dat;
          `PSCO_ADR_STATUS:  sr_r      <= i_wb_dat[15:0] & `PSCO_SR_MASK;
          `PSCO_ADR_CTRL:    page8k_r  <= i_wb_dat[1];
          `PSCO_ADR_FPSR:    fpsr_r    <= i_wb_dat;
          default: ;
        endcase
      end

      // operation sequencer
      case (state_r)
        ST_IDLE: begin
          // decode waits for go
          if (go) begin
            busy_r   <= 1'b1;
            result_r <= `PSCO_RES_OK;
            if (!supv && (is_xor || is_push || is_save || is_rest)) begin
              result_r <= `PSCO_RES_PRIV;
              busy_r   <= 1'b0;
            end else if (is_xor) begin
              // every implemented bit, flags toggle where immediate is one
              sr_r   <= (sr_r ^ operand_r) & `PSCO_SR_MASK;
              busy_r <= 1'b0;

            end else if (is_push) begin
              // page size taken from the go write
              if (sfield == `PSCO_SCOPE_ILL) begin
                result_r <= `PSCO_RES_ILLEGAL;
                busy_r   <= 1'b0;
              end else if (cfield == `PSCO_CACHE_NONE) begin
                busy_r <= 1'b0;
              end else begin
                o_cache_req   <= 1'b1;
                o_cache_sel   <= cfield;
                // only data lines are written back before invalidation
                o_cache_push  <= cfield[0];
                o_cache_scope <= sfield;
                case (sfield)
                  `PSCO_SCOPE_LINE: o_cache_mask <= `PSCO_MASK_LINE;
                  `PSCO_SCOPE_PAGE: o_cache_mask <= i_wb_dat[1] ? `PSCO_MASK_PG8K
                                                                : `PSCO_MASK_PG4K;
                  default:          o_cache_mask <= 32'h00000000;
                endcase
                o_cache_addr <= areg_r;
                state_r      <= ST_CACHE;
              end

            end else if (is_save) begin
              // id zero traps first
              if (cp_id == `PSCO_CPID_NONE) begin
                result_r <= `PSCO_RES_FLINE;
                busy_r   <= 1'b0;
              end else if (!save_ea_ok) begin
                result_r <= `PSCO_RES_ILLEGAL;
                busy_r   <= 1'b0;
              end else begin
                o_cp_save_req <= 1'b1;
                o_cp_id       <= cp_id;
                state_r       <= ST_CP;
              end

            end else if (is_rest) begin
              // modes, then frame fetch
              if (!rest_ea_ok) begin
                result_r <= `PSCO_RES_ILLEGAL;
                busy_r   <= 1'b0;
              end else begin
                o_fp_abort   <= 1'b1;
                o_frame_req  <= 1'b1;
                o_frame_addr <= areg_r;
                state_r      <= ST_FMT;
              end
            end else begin
              // unknown opcode traps
              result_r <= `PSCO_RES_ILLEGAL;
              busy_r   <= 1'b0;
            end
          end
        end

        ST_FMT: begin
          // first word at the effective address is the format word
          if (frame_rise) begin
            o_frame_req <= 1'b0;
            if (fw_size == `PSCO_COME_AGAIN) begin
              // repeat the request; interrupts must wait meanwhile
              o_int_hold  <= 1'b1;
              o_frame_req <= 1'b1;
            end else if (fdata_r == 16'h0000) begin
              // null frame behaves as a unit hardware reset
              o_int_hold   <= 1'b0;
              o_fp_reset   <= 1'b1;
              fpsr_r       <= 32'h00000000;
              frame_size_r <= `PSCO_FR_NULL;
              busy_r       <= 1'b0;
              state_r      <= ST_IDLE;
            end else if (!size_known || fw_rev != `PSCO_FP_REV) begin
              o_int_hold <= 1'b0;
              result_r   <= `PSCO_RES_FORMAT;
              busy_r     <= 1'b0;
              state_r    <= ST_IDLE;
            end else begin
              o_int_hold   <= 1'b0;
              frame_size_r <= fw_size;
              // format word itself already consumed two of the bytes
              frame_left_r <= fw_size - 8'h02;
              o_frame_addr <= o_frame_addr + 32'h00000002;
              o_frame_req  <= 1'b1;
              state_r      <= ST_BODY;
            end
          end
        end

        ST_BODY: begin
          // body words fetched upward; fp status left as it was
          if (frame_rise) begin
            if (frame_left_r <= 8'h02) begin
              o_frame_req <= 1'b0;
              busy_r      <= 1'b0;
              state_r     <= ST_IDLE;
              // closing pulse by frame kind
              case (frame_size_r)
                `PSCO_FR_IDLE4, `PSCO_FR_IDLE28, `PSCO_FR_IDLE60:
                  o_fp_idle <= 1'b1;
                `PSCO_FR_UNIMPLEMENTED_FRAME:
                  o_fp_e1_only <= 1'b1;
                default:
                  o_fp_resume <= 1'b1;
              endcase
            end else begin
              frame_left_r <= frame_left_r - 8'h02;
              o_frame_addr <= o_frame_addr + 32'h00000002;
            end
          end
        end

        ST_CACHE: begin
          // level held until done
          if (cdone_s2_r) begin
            o_cache_req <= 1'b0;
            busy_r      <= 1'b0;
            state_r     <= ST_IDLE;
          end
        end

        ST_CP: begin
          // level held until done
          if (cpdone_s2_r) begin
            o_cp_save_req <= 1'b0;
            busy_r        <= 1'b0;
            state_r       <= ST_IDLE;
          end
        end

        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== psco_defs.vh ====
`ifndef PSCO_DEFS_VH
`define PSCO_DEFS_VH
// register offsets (word indices on i_wb_adr, one per register)
`define PSCO_ADR_CMD      4'h0
`define PSCO_ADR_OPERAND  4'h1
`define PSCO_ADR_AREG     4'h2
`define PSCO_ADR_STATUS   4'h3
`define PSCO_ADR_RESULT   4'h4
`define PSCO_ADR_CTRL     4'h5
`define PSCO_ADR_FPSR     4'h6
`define PSCO_ADR_FRAME    4'h7
// opcode patterns
`define PSCO_OP_XORSR     16'h0a7c
`define PSCO_OP_PUSH_HI   8'hf4
`define PSCO_FLINE        4'hf
`define PSCO_SUB_SAVE     3'h4
`define PSCO_SUB_REST     3'h5
// effective address modes
`define PSCO_EA_IND       3'h2
`define PSCO_EA_POSTINC   3'h3
`define PSCO_EA_PREDEC    3'h4
`define PSCO_EA_DISP      3'h5
`define PSCO_EA_INDEX     3'h6
`define PSCO_EA_EXT       3'h7
`define PSCO_EAR_ABSW     3'h0
`define PSCO_EAR_ABSL     3'h1
`define PSCO_EAR_PCD      3'h2
`define PSCO_EAR_PCX      3'h3
`define PSCO_CPID_NONE    3'h0
// cache field and scope field
`define PSCO_CACHE_NONE   2'h0
`define PSCO_CACHE_DATA   2'h1
`define PSCO_CACHE_INST   2'h2
`define PSCO_CACHE_BOTH   2'h3
`define PSCO_SCOPE_ILL    2'h0
`define PSCO_SCOPE_LINE   2'h1
`define PSCO_SCOPE_PAGE   2'h2
`define PSCO_SCOPE_ALL    2'h3
// address masks
`define PSCO_MASK_LINE    32'hfffffff0
`define PSCO_MASK_PG4K    32'hfffff000
`define PSCO_MASK_PG8K    32'hffffe000
// status word
`define PSCO_SR_MASK      16'hf71f
`define PSCO_SR_RESET     16'h2700
`define PSCO_SR_SUPV      13
// fp frame sizes (bytes)
`define PSCO_FR_NULL      8'h00
`define PSCO_FR_IDLE4     8'h04
`define PSCO_FR_IDLE28    8'h1c
`define PSCO_FR_IDLE60    8'h3c
`define PSCO_FR_UNIMPLEMENTED_FRAME     8'h30
`define PSCO_FR_BUSY96    8'h60
`define PSCO_FR_BUSY184   8'hb8
`define PSCO_FR_BUSY216   8'hd8
`define PSCO_COME_AGAIN   8'h01
`define PSCO_FP_REV       8'h41 // unit revision, value arbitrary
// result codes
`define PSCO_RES_OK       3'h0
`define PSCO_RES_PRIV     3'h1
`define PSCO_RES_FLINE    3'h2
`define PSCO_RES_ILLEGAL  3'h3
`define PSCO_RES_FORMAT   3'h4
`endif

// ==== psco_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module psco_asserts (
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  input wire logic        o_frame_req,
  input wire logic [31:0] o_frame_addr,
  input wire logic        o_int_hold,
  input wire logic        o_cache_req,
  input wire logic [1:0]  o_cache_sel,
  input wire logic        o_cache_push,
  input wire logic [1:0]  o_cache_scope,
  input wire logic [31:0] o_cache_mask,
  input wire logic        o_cp_save_req,
  input wire logic [2:0]  o_cp_id
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // write-back only when the data cache is part of the request
  property p_push; o_cache_req |-> o_cache_push == o_cache_sel[0]; endproperty
  a_push: assert property (p_push) else $error("push flag off cache field");
  // cache field zero never reaches the caches
  property p_sel; o_cache_req |-> o_cache_sel != 2'h0; endproperty
  a_sel: assert property (p_sel) else $error("cache request with no cache");
  // scope zero traps, all-entries compares nothing
  property p_scope; o_cache_req |-> o_cache_scope != 2'h0 && (o_cache_scope != 2'h3 || o_cache_mask == 32'h0); endproperty
  a_scope: assert property (p_scope) else $error("bad scope on cache request");
  // line compare drops the low four address bits
  property p_line; o_cache_req && o_cache_scope == 2'h1 |-> o_cache_mask == 32'hfffffff0; endproperty
  a_line: assert property (p_line) else $error("line mask wrong");
  // page compare drops twelve or thirteen bits
  property p_page; o_cache_req && o_cache_scope == 2'h2 |-> o_cache_mask inside {32'hfffff000, 32'hffffe000}; endproperty
  a_page: assert property (p_page) else $error("page mask wrong");
  // coprocessor id zero must never be addressed
  property p_cpid; o_cp_save_req |-> o_cp_id != 3'h0; endproperty
  a_cpid: assert property (p_cpid) else $error("save sent to id zero");
  // frame words fetched upward one word at a time
  property p_step; o_frame_req && $past(o_frame_req) && o_frame_addr != $past(o_frame_addr)
    |-> o_frame_addr == $past(o_frame_addr) + 32'h2; endproperty
  a_step: assert property (p_step) else $error("frame address not ascending");
  // interrupt hold belongs to a running restore only
  property p_hold; o_int_hold |-> o_frame_req; endproperty
  a_hold: assert property (p_hold) else $error("interrupt hold outside restore");
endmodule
bind psco_core psco_asserts u_chk (.i_core_clk, .i_reset, .o_frame_req, .o_frame_addr, .o_int_hold,
  .o_cache_req, .o_cache_sel, .o_cache_push, .o_cache_scope, .o_cache_mask, .o_cp_save_req, .o_cp_id);
`default_nettype wire

// ==== psco_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module psco_partner (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_frame_req,
  input  wire logic [31:0] i_frame_addr,
  input  wire logic [15:0] i_fmt,
  input  wire logic [31:0] i_base,
  input  wire logic        i_again,
  input  wire logic        i_slow,
  input  wire logic        i_cache_req,
  input  wire logic        i_cp_req,
  output var  logic        o_frame_valid,
  output var  logic [15:0] o_frame_data,
  output var  logic [31:0] o_words,
  output var  logic        o_cache_done,
  output var  logic        o_cp_done
);
  logic [3:0] fc_r;    // word slot timer, 16 cycles a slot
  logic [3:0] cc_r;    // cache wait
  logic [3:0] pc_r;    // coprocessor wait
  logic       again_r; // one not-ready answer owed
  wire  [3:0] lat = i_slow ? 4'h6 : 4'h1; // prompt or slow answer
  // memory side: one word per slot, valid dropped between words
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {fc_r, again_r, o_frame_valid, o_frame_data, o_words} <= '0;
    end else begin
      fc_r <= (i_frame_req || fc_r != 4'h0) ? fc_r + 4'h1 : 4'h0;
      if (!i_frame_req)
        again_r <= i_again;
      if (fc_r == lat && i_frame_req) begin
        o_frame_valid <= 1'b1;
        o_words <= o_words + 32'h1;
        if (i_frame_addr == i_base && again_r) begin
          o_frame_data <= 16'h4101; // not ready, come again
          again_r <= 1'b0;
        end else begin
          o_frame_data <= (i_frame_addr == i_base) ? i_fmt : ~i_frame_addr[15:0];
        end
      end else if (fc_r == lat + 4'h4) begin
        o_frame_valid <= 1'b0;
        o_frame_data <= ~o_frame_data; // a released line keeps no value
      end
    end
  end
  // caches and coprocessor: done after a delay, held until request drops
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {cc_r, pc_r, o_cache_done, o_cp_done} <= '0;
    end else begin
      cc_r <= i_cache_req ? cc_r + {3'h0, cc_r != 4'hf} : 4'h0;
      pc_r <= i_cp_req ? pc_r + {3'h0, pc_r != 4'hf} : 4'h0;
      o_cache_done <= i_cache_req && cc_r >= lat;
      o_cp_done <= i_cp_req && pc_r >= lat;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "psco_defs.vh"
module tb;
  logic        clk, rst, cyc, stb, we, again, slow, creq_d, freq_d, cpreq_d, hold_seen;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, base, ncache, ncp, msk, fstart, tick_n, cadr;
  logic [4:0]  cfl;
  logic [2:0]  cid;
  logic [15:0] fmt, pcnt [5];
  logic [15:0] ucmd [4] = '{16'h0a7c, 16'hf4f8, 16'hf310, 16'hf350};
  logic [15:0] ftab [11] = '{16'h0000, 16'h4104, 16'h411c, 16'h413c, 16'h4130, 16'h4160,
                             16'h41b8, 16'h41d8, 16'h4155, 16'h4004, 16'h4104};
  int          failures, comparisons;
  wire  [31:0] rdat, faddr, caddr, cmask, words;
  wire  [15:0] fdata;
  wire  [4:0]  pls;
  wire  [2:0]  cpid;
  wire  [1:0]  csel, cscope;
  wire         ack, fvalid, freq, ihold, creq, push_invalidate_cache_op, cdone, cpreq, cpdone;
  psco_core dut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_frame_valid(fvalid), .i_frame_data(fdata), .o_frame_req(freq), .o_frame_addr(faddr),
    .o_fp_abort(pls[0]), .o_fp_reset(pls[1]), .o_fp_resume(pls[2]), .o_fp_idle(pls[3]),
    .o_fp_e1_only(pls[4]), .o_int_hold(ihold), .o_cache_req(creq), .o_cache_sel(csel),
    .o_cache_push(push_invalidate_cache_op), .o_cache_scope(cscope), .o_cache_addr(caddr), .o_cache_mask(cmask),
    .i_cache_done(cdone), .o_cp_save_req(cpreq), .o_cp_id(cpid), .i_cp_done(cpdone));
  psco_partner u_far (.i_clk(clk), .i_reset(rst), .i_frame_req(freq), .i_frame_addr(faddr),
    .i_fmt(fmt), .i_base(base), .i_again(again), .i_slow(slow), .i_cache_req(creq), .i_cp_req(cpreq),
    .o_frame_valid(fvalid), .o_frame_data(fdata), .o_words(words), .o_cache_done(cdone), .o_cp_done(cpdone));
  always #4 clk = ~clk;
  // tallies of pulses and request starts, taken at the edge
  always @(posedge clk) begin
    for (int j = 0; j < 5; j++)
      if (pls[j] === 1'b1)
        pcnt[j] <= pcnt[j] + 16'h1;
    if (ihold === 1'b1)
      hold_seen <= 1'b1;
    if (creq === 1'b1 && creq_d !== 1'b1) begin
      ncache <= ncache + 32'h1;
      msk <= cmask;
      cadr <= caddr;
      cfl <= {csel, push_invalidate_cache_op, cscope};
    end
    if (cpreq === 1'b1 && cpreq_d !== 1'b1) begin
      ncp <= ncp + 32'h1;
      cid <= cpid;
    end
    if (freq === 1'b1 && freq_d !== 1'b1)
      fstart <= faddr;
    {creq_d, cpreq_d, freq_d} <= {creq, cpreq, freq};
    tick_n <= tick_n + 32'h1;
    if (tick_n == 32'd60000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  // load, start, poll busy, fetch the result code
  task automatic op(input logic [15:0] c, input logic [15:0] im, input logic [31:0] ar,
                    input logic pg, output logic [31:0] r);
    logic [31:0] q;
    wb(1'b1, `PSCO_ADR_CMD, {16'h0, c}, q);
    wb(1'b1, `PSCO_ADR_OPERAND, {16'h0, im}, q);
    wb(1'b1, `PSCO_ADR_AREG, ar, q);
    wb(1'b1, `PSCO_ADR_CTRL, {30'h0, pg, 1'b1}, q);
    q = 32'h1;
    while (q[0] !== 1'b0)
      wb(1'b0, `PSCO_ADR_CTRL, 32'h0, q);
    wb(1'b0, `PSCO_ADR_RESULT, 32'h0, r);
  endtask
  function automatic logic [31:0] mask_of(input logic [1:0] sc, input logic pg);
    mask_of = (sc == 2'h1) ? 32'hfffffff0 : (sc == 2'h3) ? 32'h0 : pg ? 32'hffffe000 : 32'hfffff000;
  endfunction
  // pulse slot of a frame kind, zero when the format word is bad
  function automatic int kind_of(input logic [15:0] f);
    case (f[7:0])
      8'h04, 8'h1c, 8'h3c: kind_of = 3;
      8'h30: kind_of = 4;
      8'h60, 8'hb8, 8'hd8: kind_of = 2;
      default: kind_of = 0;
    endcase
    if (f == 16'h0)
      kind_of = 1;
    else if (f[15:8] != 8'h41)
      kind_of = 0;
  endfunction
  function automatic logic [31:0] save_res(input logic [2:0] id, input logic [2:0] md, input logic [2:0] rg);
    if (md inside {3'h2, 3'h4, 3'h5, 3'h6} || (md == 3'h7 && rg < 3'h2))
      save_res = (id == 3'h0) ? 32'h2 : 32'h0;
    else
      save_res = 32'h3;
  endfunction
  initial begin
    logic [31:0] q, r, ar, fp, k, w0, lsz;
    logic [15:0] sr, im, f, sn [5];
    logic [2:0]  md, rg, id;
    logic        pg, ok;
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, again, slow, adr, sel, wdat, base, fmt} = '0;
    pcnt = '{default: 16'h0};
    {ncache, ncp, msk, fstart, tick_n, failures, comparisons, creq_d, cpreq_d, freq_d, hold_seen, lsz} = '0;
    k = $urandom(57);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, `PSCO_ADR_STATUS, 32'h0, q);
    chk(q, 32'h2700);
    wb(1'b1, 4'hc, 32'hffffffff, q);
    wb(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0);
    // immediate xor, corner words first, supervisor bit kept
    sr = 16'h2700;
    for (int i = 0; i < 12; i++) begin
      im = (i == 0) ? 16'h001f : (i == 1) ? 16'hdfff : 16'($urandom) & 16'hdfff;
      sr = (sr ^ im) & 16'hf71f;
      op(`PSCO_OP_XORSR, im, 32'h0, 1'b0, r);
      chk(r, 32'h0);
      wb(1'b0, `PSCO_ADR_STATUS, 32'h0, q);
      chk(q, {16'h0, sr});
    end
    // in user state every operation traps and nothing moves
    op(`PSCO_OP_XORSR, 16'h2000, 32'h0, 1'b0, r);
    for (int i = 0; i < 4; i++) begin
      k = ncache + ncp + pcnt[0];
      op(ucmd[i], 16'h0004, 32'h100, 1'b0, r);
      chk(r, 32'h1);
      chk(ncache + ncp + pcnt[0], k);
    end
    wb(1'b0, `PSCO_ADR_STATUS, 32'h0, q);
    chk(q, {16'h0, sr ^ 16'h2000});
    wb(1'b1, `PSCO_ADR_STATUS, {16'h0, sr}, q);
    // every cache and scope code, random register and page size
    for (int s = 0; s < 16; s++) begin
      ar = $urandom;
      pg = 1'($urandom);
      slow <= 1'($urandom);
      k = ncache;
      op({8'hf4, 2'(s >> 2), 1'b1, 2'(s), 3'h5}, 16'h0, ar, pg, r);
      chk(r, (s % 4 == 0) ? 32'h3 : 32'h0);
      chk(ncache - k, (s > 3 && s % 4 != 0) ? 32'h1 : 32'h0);
      if (s > 3 && s % 4 != 0) begin
        chk(msk, mask_of(2'(s), pg));
        chk(cadr, ar);
        chk(cfl, {2'(s >> 2), 1'(s >> 2), 2'(s)});
      end
    end
    // save across address modes, id zero once
    for (int m = 0; m < 13; m++) begin
      md = (m < 7) ? 3'(m) : 3'h7;
      rg = (m < 7) ? 3'($urandom) : 3'(m - 7);
      id = (m == 2) ? 3'h0 : 3'($urandom % 7 + 1);
      k = ncp;
      op({4'hf, id, 3'h4, md, rg}, 16'h0, 32'h200, 1'b0, r);
      chk(r, save_res(id, md, rg));
      chk(ncp - k, (save_res(id, md, rg) == 32'h0) ? 32'h1 : 32'h0);
      if (save_res(id, md, rg) == 32'h0)
        chk(cid, id);
    end
    // restore: address modes, then each frame kind, then come-again
    for (int i = 0; i < 24; i++) begin
      md = (i < 13) ? ((i < 7) ? 3'(i) : 3'h7) : 3'h2;
      rg = (i > 6 && i < 13) ? 3'(i - 7) : 3'($urandom);
      f = (i < 13) ? 16'h4104 : ftab[i - 13];
      ar = $urandom & 32'hfffffff0;
      fp = $urandom | 32'h1;
      ok = md inside {3'h2, 3'h3, 3'h5, 3'h6} || (md == 3'h7 && rg < 3'h4);
      {fmt, base, again, slow} <= {f, ar, i == 23, 1'($urandom)};
      hold_seen = 1'b0;
      wb(1'b1, `PSCO_ADR_FPSR, fp, q);
      sn = pcnt;
      w0 = words;
      op({4'hf, 3'h1, 3'h5, md, rg}, 16'h0, ar, 1'b0, r);
      if (ok && kind_of(f) != 0)
        lsz = {24'h0, f[7:0]};
      chk(r, {lsz[4:0], 3'(!ok ? 3 : (kind_of(f) == 0) ? 4 : 0)});
      chk(pcnt[0] - sn[0], ok);
      wb(1'b0, `PSCO_ADR_FPSR, 32'h0, q);
      chk(q, (ok && f == 16'h0) ? 32'h0 : fp);
      if (ok && kind_of(f) != 0)
        chk(pcnt[kind_of(f)] - sn[kind_of(f)], 32'h1);
      if (i > 12) begin
        chk(fstart, ar);
        chk(hold_seen, i == 23);
      end
      if (i > 13 && kind_of(f) != 0)
        chk(words - w0, f[7:1] + (i == 23));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
